// ### core/dtp_top.sv
// dtp_top: two 8-bit period timers (joinable to 16 bits) and two 10-bit pwm outputs
// assumes clk is the oscillator, registers are reached over apb, pins are asynchronous
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`default_nettype none
module dtp_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic port_a_bit0_pin_i,
    output logic port_a_bit0_pin_o,
    output logic port_a_bit0_pin_oe,
    input wire logic port_c_bit0_pin_i,
    output logic port_c_bit0_pin_o,
    output logic port_c_bit0_pin_oe,
    output logic timer_a_irq,
    output logic timer_b_irq
);
    import dtp_pkg::*;

    // software-visible state and the oscillator phase
    logic [4:0] dual_timer_control;
    logic [2:0] pulse_control;
    logic [7:0] timer_a_period;
    logic [7:0] timer_b_period;
    logic [7:0] timer_a_count;
    logic [7:0] timer_b_count;
    logic [1:0] timer_flags;
    logic [1:0] timer_irq_enable;
    logic [7:0] duty_high_byte [2];
    logic [1:0] duty_low_bits [2];
    logic [1:0] port_data;
    logic [1:0] port_dir;
    logic [1:0] phase;

    logic [4:0] next_dual_timer_control;
    logic [2:0] next_pulse_control;
    logic [7:0] next_timer_a_period;
    logic [7:0] next_timer_b_period;
    logic [7:0] next_timer_a_count;
    logic [7:0] next_timer_b_count;
    logic [1:0] next_timer_flags;
    logic [1:0] next_timer_irq_enable;
    logic [7:0] next_duty_high_byte [2];
    logic [1:0] next_duty_low_bits [2];
    logic [1:0] next_port_data;
    logic [1:0] next_port_dir;
    logic [1:0] next_phase;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_port_a_bit0_pin_o;
    logic next_port_a_bit0_pin_oe;
    logic next_port_c_bit0_pin_o;
    logic next_port_c_bit0_pin_oe;
    logic next_timer_a_irq;
    logic next_timer_b_irq;

    logic [2:0] pin_raw;
    logic [2:0] pin_level;
    logic [2:0] pin_fall;
    logic wr_en;
    logic rd_phase;
    logic instr_tick;
    logic wide_mode_select;
    logic timer_a_run_enable;
    logic timer_b_run_enable;
    logic timer_a_clock_select;
    logic timer_b_clock_select;
    logic count_a_tick;
    logic count_b_tick;
    logic roll_a;
    logic roll_b;
    logic [1:0] pwm_wave;
    logic [1:0] pwm_start;
    logic [9:0] pwm_position [2];
    logic [9:0] duty_value [2];

    // sticky flag: hardware set beats a software clear in the same cycle
    function automatic logic flag_update(input logic cur, input logic set, input logic clr);
        flag_update = set | (cur & ~clr);
    endfunction : flag_update

    // address decode shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] addr);
        case (addr)
            OFS_TIMER_CTRL, OFS_PULSE_CTRL, OFS_PERIOD_A, OFS_PERIOD_B,
            OFS_COUNT_A, OFS_COUNT_B, OFS_FLAGS, OFS_IRQ_EN,
            OFS_DUTY0_HIGH, OFS_DUTY0_LOW, OFS_DUTY1_HIGH, OFS_DUTY1_LOW,
            OFS_PORT_CTRL: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // every pin passes two flops before any logic looks at it
    assign pin_raw = {port_c_bit0_pin_i, port_a_bit0_pin_i, external_count_pin};
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pin_sync
            dtp_sync u_sync (
                .clk(clk),
                .rstn(rstn),
                .pin(pin_raw[i]),
                .level(pin_level[i]),
                .fall(pin_fall[i])
            );
        end
    endgenerate

    // apb handshake: one wait state, the write lands on the pready edge
    assign rd_phase = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite & is_mapped(paddr);

    // control field aliases
    assign wide_mode_select = dual_timer_control[BIT_WIDE_MODE];
    assign timer_a_run_enable = dual_timer_control[BIT_A_RUN_ENABLE];
    assign timer_b_run_enable = dual_timer_control[BIT_B_RUN_ENABLE];
    assign timer_a_clock_select = dual_timer_control[BIT_A_CLOCK_SELECT];
    assign timer_b_clock_select = dual_timer_control[BIT_B_CLOCK_SELECT];

    // oscillator phase and instruction tick, one every four cycles
    assign instr_tick = (phase == PHASE_LAST);
    assign count_a_tick = timer_a_clock_select ? pin_fall[0] : instr_tick;
    // in wide mode b's select is ignored, whole counter follows a
    assign count_b_tick = wide_mode_select ? count_a_tick :
        (timer_b_clock_select ? pin_fall[0] : instr_tick);

    // timers: count, match, wrap; a software write to a count wins
    always_comb begin
        next_phase = 2'(phase + 2'h1);
        next_timer_a_count = timer_a_count;
        next_timer_b_count = timer_b_count;
        roll_a = 1'b0;
        roll_b = 1'b0;
        if (wide_mode_select) begin
            if (timer_a_run_enable && count_a_tick) begin
                if (timer_b_run_enable) begin
                    if ({timer_b_count, timer_a_count} == {timer_b_period, timer_a_period}) begin
                        next_timer_a_count = RST_COUNT;
                        next_timer_b_count = RST_COUNT;
                        roll_a = 1'b1;
                    end else begin
                        {next_timer_b_count, next_timer_a_count} =
                            16'({timer_b_count, timer_a_count} + 16'h0001);
                    end
                end else begin
                    next_timer_a_count = 8'(timer_a_count + 8'h01);
                end
            end
        end else begin
            if (timer_a_run_enable && count_a_tick) begin
                if (timer_a_count == timer_a_period) begin
                    next_timer_a_count = RST_COUNT;
                    roll_a = 1'b1;
                end else begin
                    next_timer_a_count = 8'(timer_a_count + 8'h01);
                end
            end
            if (timer_b_run_enable && count_b_tick) begin
                if (timer_b_count == timer_b_period) begin
                    next_timer_b_count = RST_COUNT;
                    roll_b = 1'b1;
                end else begin
                    next_timer_b_count = 8'(timer_b_count + 8'h01);
                end
            end
        end
        if (wr_en && paddr == OFS_COUNT_A) begin
            next_timer_a_count = pwdata[7:0];
        end
        if (wr_en && paddr == OFS_COUNT_B) begin
            next_timer_b_count = pwdata[7:0];
        end
    end

    // register writes and sticky flags
    always_comb begin
        next_dual_timer_control = dual_timer_control;
        next_pulse_control = pulse_control;
        next_timer_a_period = timer_a_period;
        next_timer_b_period = timer_b_period;
        next_timer_irq_enable = timer_irq_enable;
        next_duty_high_byte = duty_high_byte;
        next_duty_low_bits = duty_low_bits;
        next_port_data = port_data;
        next_port_dir = port_dir;
        if (wr_en) begin
            case (paddr)
                OFS_TIMER_CTRL: next_dual_timer_control = pwdata[4:0];
                OFS_PULSE_CTRL: next_pulse_control = pwdata[2:0];
                OFS_PERIOD_A: next_timer_a_period = pwdata[7:0];
                OFS_PERIOD_B: next_timer_b_period = pwdata[7:0];
                OFS_IRQ_EN: next_timer_irq_enable = pwdata[1:0];
                OFS_DUTY0_HIGH: next_duty_high_byte[0] = pwdata[7:0];
                OFS_DUTY0_LOW: next_duty_low_bits[0] = pwdata[DUTY_LOW_MSB:DUTY_LOW_LSB];
                OFS_DUTY1_HIGH: next_duty_high_byte[1] = pwdata[7:0];
                OFS_DUTY1_LOW: next_duty_low_bits[1] = pwdata[DUTY_LOW_MSB:DUTY_LOW_LSB];
                OFS_PORT_CTRL: begin
                    next_port_data = pwdata[BIT_PORT_C_DATA:BIT_PORT_A_DATA];
                    next_port_dir = pwdata[BIT_PORT_C_DIR:BIT_PORT_A_DIR];
                end
                default: next_port_data = port_data;
            endcase
        end
        // write one to clear; only the rollover can set a flag
        next_timer_flags[BIT_FLAG_A] = flag_update(timer_flags[BIT_FLAG_A], roll_a,
            wr_en && paddr == OFS_FLAGS && pwdata[BIT_FLAG_A]);
        next_timer_flags[BIT_FLAG_B] = flag_update(timer_flags[BIT_FLAG_B], roll_b,
            wr_en && paddr == OFS_FLAGS && pwdata[BIT_FLAG_B]);
        // request lines gated by enable
        next_timer_a_irq = next_timer_flags[BIT_FLAG_A] & timer_irq_enable[BIT_FLAG_A];
        next_timer_b_irq = next_timer_flags[BIT_FLAG_B] & timer_irq_enable[BIT_FLAG_B];
    end

    // apb read data, captured in the first access cycle
    always_comb begin
        next_pready = rd_phase;
        next_pslverr = rd_phase & ~is_mapped(paddr);
        next_prdata = prdata;
        if (rd_phase) begin
            next_prdata = 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    OFS_TIMER_CTRL: next_prdata[4:0] = dual_timer_control;
                    OFS_PULSE_CTRL: next_prdata[2:0] = pulse_control;
                    OFS_PERIOD_A: next_prdata[7:0] = timer_a_period;
                    OFS_PERIOD_B: next_prdata[7:0] = timer_b_period;
                    OFS_COUNT_A: next_prdata[7:0] = timer_a_count;
                    OFS_COUNT_B: next_prdata[7:0] = timer_b_count;
                    OFS_FLAGS: next_prdata[1:0] = timer_flags;
                    OFS_IRQ_EN: next_prdata[1:0] = timer_irq_enable;
                    OFS_DUTY0_HIGH: next_prdata[7:0] = duty_high_byte[0];
                    OFS_DUTY0_LOW: next_prdata[DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_low_bits[0];
                    OFS_DUTY1_HIGH: next_prdata[7:0] = duty_high_byte[1];
                    OFS_DUTY1_LOW: next_prdata[DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_low_bits[1];
                    OFS_PORT_CTRL: begin
                        next_prdata[BIT_PORT_C_DATA:BIT_PORT_A_DATA] = port_data;
                        next_prdata[BIT_PORT_C_DIR:BIT_PORT_A_DIR] = port_dir;
                        next_prdata[BIT_PORT_C_PIN:BIT_PORT_A_PIN] = pin_level[2:1];
                    end
                    default: next_prdata = 32'h00000000;
                endcase
            end
        end
    end

    // time base per channel: count extended by oscillator phase gives 4 tosc per step
    assign pwm_position[0] = {timer_a_count, phase};
    assign pwm_start[0] = roll_a;
    assign pwm_position[1] = pulse_control[BIT_CH1_TIMEBASE] ?
        {timer_b_count, phase} : {timer_a_count, phase};
    assign pwm_start[1] = pulse_control[BIT_CH1_TIMEBASE] ? roll_b : roll_a;
    // wide mode with pwm enabled is left to software; the waveform is then undefined
    generate
        for (genvar c = 0; c < 2; c++) begin : g_pwm
            assign duty_value[c] = {duty_high_byte[c], duty_low_bits[c]};
            dtp_pwm_chan u_chan (
                .clk(clk),
                .rstn(rstn),
                .period_start(pwm_start[c]),
                .position(pwm_position[c]),
                .duty_hold(duty_value[c]),
                .wave(pwm_wave[c])
            );
        end
    endgenerate

    // pin drive: enabled pwm overrides data and direction
    always_comb begin
        next_port_a_bit0_pin_o = pulse_control[BIT_CH0_ENABLE] ? pwm_wave[0] : port_data[0];
        next_port_a_bit0_pin_oe = pulse_control[BIT_CH0_ENABLE] | ~port_dir[0];
        next_port_c_bit0_pin_o = pulse_control[BIT_CH1_ENABLE] ? pwm_wave[1] : port_data[1];
        next_port_c_bit0_pin_oe = pulse_control[BIT_CH1_ENABLE] | ~port_dir[1];
    end

    // state registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dual_timer_control <= RST_TIMER_CTRL;
            pulse_control <= RST_PULSE_CTRL;
            timer_a_period <= RST_PERIOD;
            timer_b_period <= RST_PERIOD;
            timer_a_count <= RST_COUNT;
            timer_b_count <= RST_COUNT;
            timer_flags <= 2'h0;
            timer_irq_enable <= 2'h0;
            duty_high_byte[0] <= RST_DUTY_HIGH;
            duty_high_byte[1] <= RST_DUTY_HIGH;
            duty_low_bits[0] <= RST_DUTY_LOW;
            duty_low_bits[1] <= RST_DUTY_LOW;
            port_data <= RST_PORT_DATA;
            port_dir <= RST_PORT_DIR;
            phase <= 2'h0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            port_a_bit0_pin_o <= 1'b0;
            port_a_bit0_pin_oe <= 1'b0;
            port_c_bit0_pin_o <= 1'b0;
            port_c_bit0_pin_oe <= 1'b0;
            timer_a_irq <= 1'b0;
            timer_b_irq <= 1'b0;
        end else begin
            dual_timer_control <= next_dual_timer_control;
            pulse_control <= next_pulse_control;
            timer_a_period <= next_timer_a_period;
            timer_b_period <= next_timer_b_period;
            timer_a_count <= next_timer_a_count;
            timer_b_count <= next_timer_b_count;
            timer_flags <= next_timer_flags;
            timer_irq_enable <= next_timer_irq_enable;
            duty_high_byte <= next_duty_high_byte;
            duty_low_bits <= next_duty_low_bits;
            port_data <= next_port_data;
            port_dir <= next_port_dir;
            phase <= next_phase;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            port_a_bit0_pin_o <= next_port_a_bit0_pin_o;
            port_a_bit0_pin_oe <= next_port_a_bit0_pin_oe;
            port_c_bit0_pin_o <= next_port_c_bit0_pin_o;
            port_c_bit0_pin_oe <= next_port_c_bit0_pin_oe;
            timer_a_irq <= next_timer_a_irq;
            timer_b_irq <= next_timer_b_irq;
        end
    end
endmodule : dtp_top
`default_nettype wire

// ### core/dtp_pkg.sv
// dtp_pkg: register map, field positions, reset values and timing for the dual timer pwm unit
// assumes one 200 MHz core clock standing in for the oscillator and an apb register port
`default_nettype none
package dtp_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_PULSE_CTRL = 8'h04;
    localparam logic [7:0] OFS_PERIOD_A = 8'h08;
    localparam logic [7:0] OFS_PERIOD_B = 8'h0C;
    localparam logic [7:0] OFS_COUNT_A = 8'h10;
    localparam logic [7:0] OFS_COUNT_B = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] OFS_DUTY0_HIGH = 8'h20;
    localparam logic [7:0] OFS_DUTY0_LOW = 8'h24;
    localparam logic [7:0] OFS_DUTY1_HIGH = 8'h28;
    localparam logic [7:0] OFS_DUTY1_LOW = 8'h2C;
    localparam logic [7:0] OFS_PORT_CTRL = 8'h30;
    // dual_timer_control fields
    localparam int BIT_A_CLOCK_SELECT = 0;
    localparam int BIT_A_RUN_ENABLE = 1;
    localparam int BIT_B_CLOCK_SELECT = 2;
    localparam int BIT_B_RUN_ENABLE = 3;
    localparam int BIT_WIDE_MODE = 4;
    // pulse_control fields
    localparam int BIT_CH0_ENABLE = 0;
    localparam int BIT_CH1_ENABLE = 1;
    localparam int BIT_CH1_TIMEBASE = 2;
    // flag and irq enable fields
    localparam int BIT_FLAG_A = 0;
    localparam int BIT_FLAG_B = 1;
    // duty_low_bits field sits in bits 7:6
    localparam int DUTY_LOW_MSB = 7;
    localparam int DUTY_LOW_LSB = 6;
    // port_ctrl fields: data, direction (1 = input), synced pin level
    localparam int BIT_PORT_A_DATA = 0;
    localparam int BIT_PORT_C_DATA = 1;
    localparam int BIT_PORT_A_DIR = 2;
    localparam int BIT_PORT_C_DIR = 3;
    localparam int BIT_PORT_A_PIN = 4;
    localparam int BIT_PORT_C_PIN = 5;
    // reset values
    localparam logic [4:0] RST_TIMER_CTRL = 5'h00;
    localparam logic [2:0] RST_PULSE_CTRL = 3'h0;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
    localparam logic [1:0] RST_DUTY_LOW = 2'h0;
    localparam logic [1:0] RST_PORT_DATA = 2'h0;
    localparam logic [1:0] RST_PORT_DIR = 2'h3;
    // instruction clock is the oscillator divided by four
    localparam int OSC_PER_INSTR = 4;
    localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1);
endpackage : dtp_pkg
`default_nettype wire

// ### core/dtp_sync.sv
// dtp_sync: two-stage synchroniser for a pin, with a falling-edge pulse
// assumes the pin is asynchronous to clk; the first stage feeds only the second
`default_nettype none
module dtp_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level,
    output logic fall
);
    import dtp_pkg::*;
    logic meta;
    logic prev;
    logic next_fall;

    // edge taken between second stage and its delayed copy
    always_comb begin
        next_fall = prev & ~level;
    end

    // synchroniser chain and edge history
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b1;
            level <= 1'b1;
            prev <= 1'b1;
            fall <= 1'b0;
        end else begin
            meta <= pin;
            level <= meta;
            prev <= level;
            fall <= next_fall;
        end
    end
endmodule : dtp_sync
`default_nettype wire

// ### core/dtp_pwm_chan.sv
// dtp_pwm_chan: one pwm channel with active duty latch and compare against the time base
// assumes period_start pulses on the edge at which the time base returns to zero
`default_nettype none
module dtp_pwm_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic period_start,
    input wire logic [9:0] position,
    input wire logic [9:0] duty_hold,
    output logic wave
);
    import dtp_pkg::*;
    logic [9:0] duty_active;
    logic [9:0] next_duty_active;
    logic next_wave;

    // holding latch copied only at a new period; output set then unless the new duty is zero, cleared at the duty point
    always_comb begin
        next_duty_active = duty_active;
        next_wave = wave;
        if (period_start) begin
            next_duty_active = duty_hold;
            next_wave = (duty_hold != 10'h000);
        end else if (wave && (10'(position + 10'h001) == duty_active)) begin
            next_wave = 1'b0;
        end
    end

    // a duty above the last position never clears the output: period_start wins a match at the last position, so it stays high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            duty_active <= 10'h000;
            wave <= 1'b0;
        end else begin
            duty_active <= next_duty_active;
            wave <= next_wave;
        end
    end
endmodule : dtp_pwm_chan
`default_nettype wire

// ### bench/dtp_checker.sv
// dtp_checker: port-level assertions for dtp_top
// assumes one clock domain and an apb master with one wait state
`default_nettype none
module dtp_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic port_a_bit0_pin_oe,
    input wire logic port_c_bit0_pin_oe,
    input wire logic timer_a_irq,
    input wire logic timer_b_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic next_wr, wr1, wr2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_unmapped;
        pready && (paddr > 8'h30 || paddr[1:0] != 2'h0);
    endsequence
    // two-cycle trail of writes: enables may only move, and irqs only fall, inside it
    always_comb next_wr = psel && penable && pready && pwrite;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr1 <= 1'b0;
            wr2 <= 1'b0;
        end else begin
            wr1 <= next_wr;
            wr2 <= wr1;
        end
    end
    a_ready_wait: assert property (s_wait |=> pready) else $error("no ready after wait");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_unmapped: assert property (s_unmapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    a_err_mapped: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped refused");
    a_oe_a_write: assert property ($changed(port_a_bit0_pin_oe) |-> wr1 || wr2)
        else $error("pin a enable moved alone");
    a_oe_c_write: assert property ($changed(port_c_bit0_pin_oe) |-> wr1 || wr2)
        else $error("pin c enable moved alone");
    a_irq_a_held: assert property ($fell(timer_a_irq) |-> wr1 || wr2)
        else $error("irq a dropped alone");
    a_irq_b_held: assert property ($fell(timer_b_irq) |-> wr1 || wr2)
        else $error("irq b dropped alone");
endmodule : dtp_checker
bind dtp_top dtp_checker dtp_checker_i (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .port_a_bit0_pin_oe, .port_c_bit0_pin_oe, .timer_a_irq,
    .timer_b_irq);
`default_nettype wire

// ### bench/dtp_partner.sv
// dtp_partner: external count source and pin loads for dtp_top
// assumes pull-ups on both pwm pins and a count line resting high
`default_nettype none
module dtp_partner (
    input wire logic fire,
    input wire logic [7:0] edges,
    input wire logic a_o,
    input wire logic a_oe,
    input wire logic c_o,
    input wire logic c_oe,
    output logic count_pin,
    output logic a_pin,
    output logic c_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven pins float up to the pull-up level
    assign a_pin = a_oe ? a_o : 1'b1;
    assign c_pin = c_oe ? c_o : 1'b1;
    // slow bursts unrelated to clk, so the sync stage is exercised
    initial begin
        count_pin = 1'b1;
        forever begin
            @(posedge fire);
            repeat (edges) begin
                #23.3 count_pin = 1'b0;
                #23.3 count_pin = 1'b1;
            end
        end
    end
endmodule : dtp_partner
`default_nettype wire

// ### bench/dual_timer_pwm_unit_tb.sv
// dual_timer_pwm_unit_tb: self-checking bench for dtp_top
// assumes dtp_checker bound in and dtp_partner standing at the pins
`default_nettype none
module dual_timer_pwm_unit_tb;
    import dtp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
    logic [7:0] paddr = 8'h00, edges = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ecp, a_i, a_o, a_oe, c_i, c_o, c_oe, irq_a, irq_b;
    int num_errors = 0, compares = 0, cycles = 0, seed = 16783, p, d, hi, rises, len;
    logic [7:0] rst_adr[5] = '{OFS_TIMER_CTRL, OFS_PERIOD_A, OFS_PERIOD_B, OFS_FLAGS, 8'h40};
    logic [31:0] rst_val[5] = '{32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0};
    dtp_top dtp_top_i (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_count_pin(ecp), .port_a_bit0_pin_i(a_i),
        .port_a_bit0_pin_o(a_o), .port_a_bit0_pin_oe(a_oe), .port_c_bit0_pin_i(c_i),
        .port_c_bit0_pin_o(c_o), .port_c_bit0_pin_oe(c_oe), .timer_a_irq(irq_a),
        .timer_b_irq(irq_b));
    dtp_partner dtp_partner_i (.fire, .edges, .a_o, .a_oe, .c_o, .c_oe, .count_pin(ecp),
        .a_pin(a_i), .c_pin(c_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // one apb transfer; an idle edge follows so psel never toggles twice per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        check(rd, v);
    endtask : rd_chk
    task automatic pulse(input int n);
        edges <= 8'(n);
        fire <= 1'b1;
        @(posedge clk) fire <= 1'b0;
        repeat (10 * n + 20) @(posedge clk);
    endtask : pulse
    // reference: high clocks per period; a high byte above the period means always high
    function automatic int model_high(input int dv, input int pr);
        return (dv >> 2) > pr ? (pr + 1) * 4 : dv;
    endfunction : model_high
    // any window of four whole periods holds four times the high time
    task automatic measure(input int ch);
        logic prev, now;
        hi = 0;
        rises = 0;
        prev = ch ? c_i : a_i;
        repeat (4 * len) begin
            @(posedge clk);
            now = ch ? c_i : a_i;
            hi += int'(now);
            rises += int'(now && !prev);
            prev = now;
        end
    endtask : measure
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard, far above the few thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (rst_adr[i]) begin
            rd_chk(rst_adr[i], rst_val[i]);
            check(32'(err), 32'(i == 4));
        end
        for (int ch = 0; ch < 2; ch++) begin
            p = 2 + {$random(seed)} % 8;
            len = (p + 1) * 4;
            apb(1'b1, ch ? OFS_PERIOD_B : OFS_PERIOD_A, 32'(p));
            // restart the time base below its new period, else it first runs up to FF and wraps
            apb(1'b1, ch ? OFS_COUNT_B : OFS_COUNT_A, 32'h0);
            apb(1'b1, OFS_TIMER_CTRL, 32'h0A);
            apb(1'b1, OFS_PULSE_CTRL, ch ? 32'h06 : 32'h01);
            @(posedge clk); // pin enables are registered one edge after the write lands
            check(32'(ch ? {c_oe, a_oe} : {a_oe, c_oe}), 32'h2);
            for (int k = 0; k < 4; k++) begin
                d = k == 0 ? 0 : k == 1 ? {$random(seed)} % len : k == 2 ? 4 * p + 3 : len;
                apb(1'b1, ch ? OFS_DUTY1_HIGH : OFS_DUTY0_HIGH, 32'(d >> 2));
                apb(1'b1, ch ? OFS_DUTY1_LOW : OFS_DUTY0_LOW, 32'((d & 3) << 6));
                repeat (2 * len) @(posedge clk);
                measure(ch);
                check(32'(hi), 32'(4 * model_high(d, p)));
                check(32'(rises), (d == 0 || (d >> 2) > p) ? 32'h0 : 32'h4);
            end
        end
        apb(1'b1, OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_IRQ_EN, 32'h1);
        repeat (100) @(posedge clk);
        check(32'({irq_b, irq_a}), 32'h1);
        apb(1'b1, OFS_IRQ_EN, 32'h3);
        rd_chk(OFS_FLAGS, 32'h3);
        check(32'({irq_b, irq_a}), 32'h3);
        apb(1'b1, OFS_PULSE_CTRL, 32'h0);
        apb(1'b1, OFS_TIMER_CTRL, 32'h0);
        apb(1'b1, OFS_FLAGS, 32'h3);
        repeat (100) @(posedge clk);
        rd_chk(OFS_FLAGS, 32'h0);
        check(32'({irq_b, irq_a}), 32'h0);
        apb(1'b1, OFS_PERIOD_A, 32'hFF);
        apb(1'b1, OFS_PERIOD_B, 32'hFF);
        apb(1'b1, OFS_COUNT_A, 32'h0);
        apb(1'b1, OFS_COUNT_B, 32'hF0);
        apb(1'b1, OFS_TIMER_CTRL, 32'h0F);
        d = 1 + {$random(seed)} % 8;
        pulse(d);
        rd_chk(OFS_COUNT_A, 32'(d));
        rd_chk(OFS_COUNT_B, 32'(240 + d));
        apb(1'b1, OFS_TIMER_CTRL, 32'h0);
        apb(1'b1, OFS_PERIOD_A, 32'h03);
        apb(1'b1, OFS_PERIOD_B, 32'h01);
        apb(1'b1, OFS_COUNT_A, 32'hFE);
        apb(1'b1, OFS_COUNT_B, 32'h0);
        apb(1'b1, OFS_TIMER_CTRL, 32'h1B);
        pulse(6);
        rd_chk(OFS_COUNT_B, 32'h0);
        rd_chk(OFS_FLAGS, 32'h1);
        apb(1'b1, OFS_TIMER_CTRL, 32'h13);
        pulse(4);
        rd_chk(OFS_COUNT_A, 32'h4);
        apb(1'b1, OFS_TIMER_CTRL, 32'h18);
        pulse(3);
        rd_chk(OFS_COUNT_A, 32'h4);
        rd_chk(OFS_COUNT_B, 32'h0);
        final_report();
    end
endmodule : dual_timer_pwm_unit_tb
`default_nettype wire
